// ---- include/sfr_map.vh ----
// register map, field positions and reset values of the frame reference control block
`ifndef SFR_MAP_VH
`define SFR_MAP_VH

// word indices, byte address is four times the index
`define SFR_IDX_POWER    10'h140
`define SFR_IDX_SYNC     10'h143
`define SFR_IDX_MODE     10'h144
`define SFR_IDX_PULSE    10'h145
`define SFR_IDX_SYNCBLK  10'h146
`define SFR_IDX_DDLYPD   10'h147
`define SFR_IDX_LANE     10'h148
`define SFR_IDX_DIV      10'h149
`define SFR_IDX_STATUS   10'h14a

// frame_ref_power_control fields
`define SFR_PWR_BLOCK_PD 0
`define SFR_PWR_GDLY_PD  1
`define SFR_PWR_BURST_PD 2
`define SFR_POWER_RST    8'h07

// sync_control fields
`define SFR_SYN_GATE_EN  0
`define SFR_SYN_LCLR     1
`define SFR_SYN_POL      2
`define SFR_SYN_ONESHOT  3
`define SFR_SYN_MODE_LSB 4
`define SFR_SYN_SRC_LSB  6
`define SFR_SYNC_RST     8'h02

// mode register fields
`define SFR_MOD_REQ_EN   0
`define SFR_MOD_REF0_SEL 1
`define SFR_MODE_RST     8'h02

// lane register fields
`define SFR_LANE_SEL_LSB 0
`define SFR_LANE_PD_LSB  8
`define SFR_LANE_DLY_LSB 16
`define SFR_LANE_RST     32'h00007f00

// other reset values
`define SFR_PULSE_RST    8'h00
`define SFR_SYNCBLK_RST  8'hff
`define SFR_DDLYPD_RST   8'h7f
`define SFR_DIV_RST      13'h0008

// trigger kinds
`define SFR_TRIG_NONE    2'h0
`define SFR_TRIG_SYNC    2'h1
`define SFR_TRIG_PIN     2'h2
`define SFR_TRIG_WRITE   2'h3

// source selector values
`define SFR_SRC_SYNC     2'h0
`define SFR_SRC_RECLK    2'h1
`define SFR_SRC_BURST    2'h2
`define SFR_SRC_CONT     2'h3

// bus responses
`define SFR_RESP_OKAY    2'h0
`define SFR_RESP_SLVERR  2'h2

`endif

// ---- logic/sfr_frame_pulse_gen.v ----
// frame reference divider with burst and continuous pulse gating
`timescale 1ns/1ps
module sfr_frame_pulse_gen #(
  parameter DW = 13
) (
  // clock and reset
  input  wire          clk,
  input  wire          nrst,
  // control
  input  wire          enable,
  input  wire [DW-1:0] div,
  input  wire          restart,
  input  wire          burst_start,
  input  wire [1:0]    burst_code,
  input  wire          run_cont,
  // results
  output wire          wave,
  output wire          wrap,
  output wire          busy
);

  reg  [DW-1:0] cnt;
  reg           active;
  reg  [3:0]    remaining;
  wire          high_half;

  assign wrap      = enable & (cnt >= div - 1'b1);
  assign high_half = cnt < (div >> 1);
  assign wave      = active & high_half;
  assign busy      = active | (remaining != 4'h0);

  always @(posedge clk) begin
    if (!nrst || !enable || restart) begin
      cnt <= {DW{1'b0}};
    end else if (wrap) begin
      cnt <= {DW{1'b0}};
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  // gating changes only at the period end, so no runt pulse
  always @(posedge clk) begin
    if (!nrst || !enable) begin
      active    <= 1'b0;
      remaining <= 4'h0;
    end else begin
      if (burst_start) begin
        remaining <= 4'h1 << burst_code;
      end else if (wrap && !run_cont && remaining != 4'h0) begin
        remaining <= remaining - 1'b1;
      end
      if (wrap) begin
        active <= run_cont | (remaining != 4'h0);
      end
    end
  end

endmodule

// ---- logic/sfr_frame_ref_ctrl.v ----
// sync and frame reference control with its register slave
// Operation
// - sync and frame reference pulses share one path to the dividers
// - a divider is reset only while its sync block bit is clear
// - trigger 0 source 0 no sync unless reference select is 0; trigger 1 basic sync, polarity selectable
// - reference select 0 makes reference input 0 the sync input when trigger and source are each 0 or 1
// - trigger 2 source 2: each sync edge fires a burst
// - trigger 3 source 2: pulse count write fires a burst
// - trigger 1 source 1: sync re-clocked by the frame divider
// - trigger 0 source 2 request: continuous pulses while sync asserted
// - source 3 gives continuous pulses when powered correctly
// - direct mode fans the input frame reference straight out
// - a lane carries frame reference only when its select is 1
// - no frame reference passes the local delay while clear is set
// - all enabled dividers restart on one sync edge
// - digital delay takes effect only after a sync event
// - bursts of 1, 2, 4 or 8 pulses
// - local delay clear resets to 1
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "sfr_map.vh"
module sfr_frame_ref_ctrl #(
  parameter NDIV = 7,
  parameter NLANE = 7,
  parameter DW = 13,
  parameter AW = 12
) (
  // clock and reset
  input  wire             SYS_CLK,
  input  wire             NRST,
  // register bus write
  input  wire [AW-1:0]    S_AXI_AWADDR,
  input  wire             S_AXI_AWVALID,
  output reg              S_AXI_AWREADY,
  input  wire [31:0]      S_AXI_WDATA,
  input  wire [3:0]       S_AXI_WSTRB,
  input  wire             S_AXI_WVALID,
  output reg              S_AXI_WREADY,
  output reg  [1:0]       S_AXI_BRESP,
  output reg              S_AXI_BVALID,
  input  wire             S_AXI_BREADY,
  // register bus read
  input  wire [AW-1:0]    S_AXI_ARADDR,
  input  wire             S_AXI_ARVALID,
  output reg              S_AXI_ARREADY,
  output reg  [31:0]      S_AXI_RDATA,
  output reg  [1:0]       S_AXI_RRESP,
  output reg              S_AXI_RVALID,
  input  wire             S_AXI_RREADY,
  // sync inputs
  input  wire             SYNC_PIN,
  input  wire             REF_INPUT0,
  input  wire             EXT_FRAME_REF,
  // divider control
  output reg  [NDIV-1:0]  DEVCLK_DIV_RESET,
  output reg              FRAME_DIV_RESET,
  output reg  [NDIV-1:0]  DELAY_APPLIED,
  // reference output lanes
  output reg  [NLANE-1:0] REF_OUTPUT_LANE
);

  function is_mapped;
    input [9:0] idx;
    begin
      is_mapped = (idx == `SFR_IDX_POWER) || (idx == `SFR_IDX_SYNC) ||
                  ((idx >= `SFR_IDX_MODE) && (idx <= `SFR_IDX_STATUS));
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0]  s;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (s[k]) merge[8*k +: 8] = d[8*k +: 8];
      end
    end
  endfunction

  // registers
  reg  [7:0]    power_ctl;
  reg  [7:0]    sync_ctl;
  reg  [7:0]    mode_ctl;
  reg  [7:0]    pulse_ctl;
  reg  [7:0]    sync_blk;
  reg  [7:0]    ddly_pd;
  reg  [31:0]   lane_ctl;
  reg  [DW-1:0] frame_div;

  // bus state
  reg  [AW-1:0] aw_addr;
  reg           aw_have;
  reg  [31:0]   w_data;
  reg  [3:0]    w_strb;
  reg           w_have;
  reg           next_aw_have;
  reg           next_w_have;
  reg  [31:0]   rd_word;
  wire          aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  wire          w_take = S_AXI_WVALID & S_AXI_WREADY;
  wire          ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
  wire          wr_go = aw_have & w_have & ~S_AXI_BVALID;
  wire [9:0]    wr_idx = aw_addr[11:2];
  wire [9:0]    rd_idx = S_AXI_ARADDR[11:2];
  wire          pulse_wr = wr_go & (wr_idx == `SFR_IDX_PULSE) & w_strb[0];
  wire [31:0]   div_merged = merge({{(32-DW){1'b0}}, frame_div}, w_data, w_strb);

  // field views
  wire          block_pd = power_ctl[`SFR_PWR_BLOCK_PD];
  wire          gdly_pd = power_ctl[`SFR_PWR_GDLY_PD];
  wire          burst_pd = power_ctl[`SFR_PWR_BURST_PD];
  wire          gate_en = sync_ctl[`SFR_SYN_GATE_EN];
  wire          lclr = sync_ctl[`SFR_SYN_LCLR];
  wire          pol = sync_ctl[`SFR_SYN_POL];
  wire          one_shot = sync_ctl[`SFR_SYN_ONESHOT];
  wire [1:0]    trig = sync_ctl[`SFR_SYN_MODE_LSB +: 2];
  wire [1:0]    src = sync_ctl[`SFR_SYN_SRC_LSB +: 2];
  wire          req_en = mode_ctl[`SFR_MOD_REQ_EN];
  wire          ref0_sel = mode_ctl[`SFR_MOD_REF0_SEL];
  wire [3:0]    lane_dly = lane_ctl[`SFR_LANE_DLY_LSB +: 4];

  // sync state
  reg           sync_prev;
  reg           reclk_level;
  reg           path_q;
  reg           path_prev;
  reg           next_path;
  wire          gen_wave;
  wire          gen_wrap;
  wire          gen_busy;

  wire ref_path = ~ref0_sel & ~trig[1] & ~src[1];
  wire sync_src = ref_path ? REF_INPUT0 : SYNC_PIN;
  wire sync_level = sync_src ^ pol;
  wire sync_rise = sync_level & ~sync_prev;
  wire cont_ok = ~block_pd & ~gdly_pd & burst_pd;
  wire req_mode = (trig == `SFR_TRIG_NONE) & (src == `SFR_SRC_BURST) & req_en;
  wire run_cont = ((src == `SFR_SRC_CONT) & cont_ok) | (req_mode & sync_level);
  wire burst_start = (src == `SFR_SRC_BURST) & ~burst_pd &
                     (((trig == `SFR_TRIG_PIN) & sync_rise) |
                      ((trig == `SFR_TRIG_WRITE) & pulse_wr));
  wire direct_fan = (trig == `SFR_TRIG_NONE) & (src == `SFR_SRC_SYNC) & ~ref0_sel &
                    (lane_dly == 4'h0) & block_pd & gdly_pd & burst_pd;
  wire path_rise = path_q & ~path_prev;
  wire div_pulse = gate_en & (one_shot ? path_rise : path_q);
  wire frame_rst = div_pulse & ~sync_blk[7];

  // common sync and frame reference path
  always @* begin
    case (src)
      `SFR_SRC_SYNC: next_path = ((trig == `SFR_TRIG_SYNC) | ref_path) & sync_level;
      `SFR_SRC_RECLK: next_path = ((trig == `SFR_TRIG_SYNC) | ref_path) & reclk_level;
      `SFR_SRC_BURST: next_path = gen_wave;
      `SFR_SRC_CONT: next_path = gen_wave;
      default: next_path = 1'b0;
    endcase
  end

  sfr_frame_pulse_gen #(
    .DW (DW)
  ) u_gen (
    .clk         (SYS_CLK),
    .nrst        (NRST),
    .enable      (~block_pd & (src != `SFR_SRC_SYNC)),
    .div         (frame_div),
    .restart     (frame_rst),
    .burst_start (burst_start),
    .burst_code  (pulse_wr ? w_data[1:0] : pulse_ctl[1:0]),
    .run_cont    (run_cont),
    .wave        (gen_wave),
    .wrap        (gen_wrap),
    .busy        (gen_busy)
  );

  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      sync_prev        <= 1'b0;
      reclk_level      <= 1'b0;
      path_q           <= 1'b0;
      path_prev        <= 1'b0;
      DEVCLK_DIV_RESET <= {NDIV{1'b0}};
      FRAME_DIV_RESET  <= 1'b0;
      DELAY_APPLIED    <= {NDIV{1'b0}};
    end else begin
      sync_prev <= sync_level;
      if (gen_wrap) begin
        reclk_level <= sync_level;
      end
      path_q           <= next_path;
      path_prev        <= path_q;
      DEVCLK_DIV_RESET <= {NDIV{div_pulse}} & ~sync_blk[NDIV-1:0];
      FRAME_DIV_RESET  <= frame_rst;
      DELAY_APPLIED    <= DELAY_APPLIED |
                          ({NDIV{div_pulse}} & ~sync_blk[NDIV-1:0] & ~ddly_pd[NDIV-1:0]);
    end
  end

  // per-lane local delay and output gating
  wire [NLANE-1:0] lane_on = lane_ctl[`SFR_LANE_SEL_LSB +: NLANE] &
                             ~lane_ctl[`SFR_LANE_PD_LSB +: NLANE];
  wire [NLANE-1:0] lane_next;
  genvar i;
  generate
    for (i = 0; i < NLANE; i = i + 1) begin : g_lane
      reg  [15:0] shreg;
      wire        tap = (lane_dly == 4'h0) ? path_q : shreg[lane_dly - 4'h1];
      always @(posedge SYS_CLK) begin
        if (!NRST || lclr) begin
          shreg <= 16'h0000;
        end else begin
          shreg <= {shreg[14:0], path_q};
        end
      end
      assign lane_next[i] = lane_on[i] & (direct_fan ? EXT_FRAME_REF : tap & ~lclr);
    end
  endgenerate

  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      REF_OUTPUT_LANE <= {NLANE{1'b0}};
    end else begin
      REF_OUTPUT_LANE <= lane_next;
    end
  end

  // write channel
  always @* begin
    next_aw_have = (aw_have | aw_take) & ~wr_go;
    next_w_have  = (w_have | w_take) & ~wr_go;
  end

  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      aw_addr       <= {AW{1'b0}};
      aw_have       <= 1'b0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      w_have        <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `SFR_RESP_OKAY;
    end else begin
      if (aw_take) aw_addr <= S_AXI_AWADDR;
      if (w_take) begin
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      aw_have       <= next_aw_have;
      w_have        <= next_w_have;
      S_AXI_AWREADY <= ~next_aw_have;
      S_AXI_WREADY  <= ~next_w_have;
      if (wr_go) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (is_mapped(wr_idx) && wr_idx != `SFR_IDX_STATUS) ?
                        `SFR_RESP_OKAY : `SFR_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // register writes
  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      power_ctl <= `SFR_POWER_RST;
      sync_ctl  <= `SFR_SYNC_RST;
      mode_ctl  <= `SFR_MODE_RST;
      pulse_ctl <= `SFR_PULSE_RST;
      sync_blk  <= `SFR_SYNCBLK_RST;
      ddly_pd   <= `SFR_DDLYPD_RST;
      lane_ctl  <= `SFR_LANE_RST;
      frame_div <= `SFR_DIV_RST;
    end else if (wr_go) begin
      case (wr_idx)
        `SFR_IDX_POWER: power_ctl <= w_strb[0] ? w_data[7:0] : power_ctl;
        `SFR_IDX_SYNC: sync_ctl <= w_strb[0] ? w_data[7:0] : sync_ctl;
        `SFR_IDX_MODE: mode_ctl <= w_strb[0] ? {6'h00, w_data[1:0]} : mode_ctl;
        `SFR_IDX_PULSE: pulse_ctl <= w_strb[0] ? {6'h00, w_data[1:0]} : pulse_ctl;
        `SFR_IDX_SYNCBLK: sync_blk <= w_strb[0] ? w_data[7:0] : sync_blk;
        `SFR_IDX_DDLYPD: ddly_pd <= w_strb[0] ? w_data[7:0] : ddly_pd;
        `SFR_IDX_LANE: lane_ctl <= merge(lane_ctl, w_data, w_strb) & 32'h000f7f7f;
        `SFR_IDX_DIV: frame_div <= div_merged[DW-1:0];
        default: sync_blk <= sync_blk;
      endcase
    end
  end

  // read channel
  always @* begin
    rd_word = 32'h00000000;
    case (rd_idx)
      `SFR_IDX_POWER: rd_word[7:0] = power_ctl;
      `SFR_IDX_SYNC: rd_word[7:0] = sync_ctl;
      `SFR_IDX_MODE: rd_word[7:0] = mode_ctl;
      `SFR_IDX_PULSE: rd_word[7:0] = pulse_ctl;
      `SFR_IDX_SYNCBLK: rd_word[7:0] = sync_blk;
      `SFR_IDX_DDLYPD: rd_word[7:0] = ddly_pd;
      `SFR_IDX_LANE: rd_word = lane_ctl;
      `SFR_IDX_DIV: rd_word[DW-1:0] = frame_div;
      `SFR_IDX_STATUS: rd_word = {17'h00000, DELAY_APPLIED, 5'h00, path_q, sync_level, gen_busy};
      default: rd_word = 32'h00000000;
    endcase
  end

  always @(posedge SYS_CLK) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `SFR_RESP_OKAY;
    end else if (ar_take) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_word;
      S_AXI_RRESP   <= is_mapped(rd_idx) ? `SFR_RESP_OKAY : `SFR_RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end else if (!S_AXI_RVALID) begin
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule

// ---- tb/sfr_frame_ref_ctrl_assertions.sv ----
// bus handshake and control output checks for the frame reference control block
`timescale 1ns/1ps
module sfr_ctrl_checker #(
  parameter NDIV  = 7,
  parameter NLANE = 7
) (
  // clock and reset
  input wire             SYS_CLK,
  input wire             NRST,
  // register bus
  input wire             S_AXI_AWVALID,
  input wire             S_AXI_AWREADY,
  input wire             S_AXI_WVALID,
  input wire             S_AXI_WREADY,
  input wire [1:0]       S_AXI_BRESP,
  input wire             S_AXI_BVALID,
  input wire             S_AXI_BREADY,
  input wire             S_AXI_ARVALID,
  input wire             S_AXI_ARREADY,
  input wire             S_AXI_RVALID,
  input wire             S_AXI_RREADY,
  // control outputs
  input wire [NDIV-1:0]  DELAY_APPLIED,
  input wire [NLANE-1:0] REF_OUTPUT_LANE
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);
  sequence s_wr_take;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rd_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  a_ready_after_reset: assert property ($rose(NRST) |=> S_AXI_AWREADY && S_AXI_ARREADY)
    else $error("bus not ready after reset");
  a_lanes_after_reset: assert property ($rose(NRST) |-> (REF_OUTPUT_LANE == '0) [*3])
    else $error("lane active while delay clear set");
  a_delay_stays_set: assert property ((~DELAY_APPLIED & $past(DELAY_APPLIED)) == '0)
    else $error("delay applied flag fell");
  a_bvalid_held: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_rvalid_held: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
    else $error("read data dropped");
  a_write_refused: assert property ((S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY) and
    (S_AXI_WVALID && S_AXI_WREADY |=> !S_AXI_WREADY))
    else $error("write taken while one is held");
  a_read_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken during data");
  a_write_answer: assert property (s_wr_take |-> ##[1:2] S_AXI_BVALID)
    else $error("write response late");
  a_read_answer: assert property (s_rd_take |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read data late");
endmodule

bind sfr_frame_ref_ctrl sfr_ctrl_checker #(.NDIV(NDIV), .NLANE(NLANE)) i_chk (
  .SYS_CLK(SYS_CLK), .NRST(NRST),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .DELAY_APPLIED(DELAY_APPLIED), .REF_OUTPUT_LANE(REF_OUTPUT_LANE)
);

// ---- tb/sfr_lane_sink.sv ----
// receiving side model: counts frame reference pulses and divider resets
`timescale 1ns/1ps
module sfr_lane_sink (
  // clock and reset
  input  wire       clk,
  input  wire       nrst,
  // observed clocks
  input  wire [6:0] lane,
  input  wire [6:0] div_rst,
  // counts of rising edges
  output integer    n_l0,
  output integer    n_l1,
  output integer    n_d0
);
  reg [6:0] pl;
  reg [6:0] pd;
  always @(posedge clk) begin
    pl <= lane;
    pd <= div_rst;
    if (!nrst) begin
      n_l0 <= 0;
      n_l1 <= 0;
      n_d0 <= 0;
    end else begin
      if (lane[0] && !pl[0]) n_l0 <= n_l0 + 1;
      if (lane[1] && !pl[1]) n_l1 <= n_l1 + 1;
      if (div_rst[0] && !pd[0]) n_d0 <= n_d0 + 1;
    end
  end
endmodule

// ---- tb/tb_sync_frame_ref_control.sv ----
// register-level tests of the frame reference control block
`timescale 1ns/1ps
`include "sfr_map.vh"
module tb_sync_frame_ref_control;
  reg         clk, nrst, awv, wv, bready, arv, rready, pin, ref0, ext;
  reg  [11:0] awaddr, araddr;
  reg  [31:0] wdata;
  wire        aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  wire [1:0]  b_resp, r_resp;
  wire [31:0] r_data;
  wire [6:0]  d_rst, d_app, lane;
  wire        f_rst;
  integer     fails, compares, base, c, n_l0, n_l1, n_d0;
  always #4 clk = ~clk;
  sfr_frame_ref_ctrl i_dut (
    .SYS_CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ar_rdy),
    .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(rready),
    .SYNC_PIN(pin), .REF_INPUT0(ref0), .EXT_FRAME_REF(ext), .DEVCLK_DIV_RESET(d_rst),
    .FRAME_DIV_RESET(f_rst), .DELAY_APPLIED(d_app), .REF_OUTPUT_LANE(lane));
  sfr_lane_sink i_sink (.clk(clk), .nrst(nrst), .lane(lane), .div_rst(d_rst),
    .n_l0(n_l0), .n_l1(n_l1), .n_d0(n_d0));
  task chk(input ok, input [127:0] m);
    begin
      compares = compares + 1;
      if (ok !== 1'b1) begin
        fails = fails + 1;
        $display("mismatch at %0t: %0s", $time, m);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input [9:0] i, input [31:0] d, input [1:0] e);
    reg a, w;
    begin
      @(posedge clk);
      awaddr <= {i, 2'b00};
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      a = 1'b1;
      w = 1'b1;
      while (a || w) begin
        @(posedge clk);
        a = a && (aw_rdy !== 1'b1);
        w = w && (w_rdy !== 1'b1);
        awv <= a;
        wv <= w;
      end
      do @(posedge clk); while (b_v !== 1'b1);
      bready <= 1'b0;
      chk(b_resp === e, "write response");
    end
  endtask
  task rd(input [9:0] i, input [31:0] x, input [1:0] e);
    begin
      @(posedge clk);
      araddr <= {i, 2'b00};
      arv <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (ar_rdy !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (r_v !== 1'b1);
      rready <= 1'b0;
      chk(r_data === x && r_resp === e, "read value");
    end
  endtask
  task give_verdict;
    begin
      if (fails == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    fails = fails + 1;
    give_verdict;
  end
  initial begin
    {clk, nrst, awv, wv, bready, arv, rready, pin, ref0, ext} = 10'h000;
    {awaddr, araddr, wdata} = 56'h0;
    fails = 0;
    compares = 0;
    wt(4);
    nrst <= 1'b1;
    rd(`SFR_IDX_POWER, `SFR_POWER_RST, `SFR_RESP_OKAY);
    rd(`SFR_IDX_SYNC, `SFR_SYNC_RST, `SFR_RESP_OKAY);
    rd(`SFR_IDX_MODE, `SFR_MODE_RST, `SFR_RESP_OKAY);
    rd(`SFR_IDX_PULSE, `SFR_PULSE_RST, `SFR_RESP_OKAY);
    rd(`SFR_IDX_SYNCBLK, `SFR_SYNCBLK_RST, `SFR_RESP_OKAY);
    rd(`SFR_IDX_DDLYPD, `SFR_DDLYPD_RST, `SFR_RESP_OKAY);
    rd(`SFR_IDX_LANE, `SFR_LANE_RST, `SFR_RESP_OKAY);
    rd(`SFR_IDX_DIV, `SFR_DIV_RST, `SFR_RESP_OKAY);
    rd(10'h150, 32'h0, `SFR_RESP_SLVERR);
    wr(`SFR_IDX_STATUS, 32'h0, `SFR_RESP_SLVERR);
    // basic sync on divider 0 and the frame divider
    wr(`SFR_IDX_SYNCBLK, 8'h7e, `SFR_RESP_OKAY);
    wr(`SFR_IDX_DDLYPD, 8'h7e, `SFR_RESP_OKAY);
    wr(`SFR_IDX_SYNC, 8'h14, `SFR_RESP_OKAY);
    wr(`SFR_IDX_SYNC, 8'h10, `SFR_RESP_OKAY);
    wr(`SFR_IDX_SYNC, 8'h05, `SFR_RESP_OKAY);
    wr(`SFR_IDX_SYNC, 8'h01, `SFR_RESP_OKAY);
    chk(n_d0 === 0 && d_app === 7'h00, "sync while off");
    wr(`SFR_IDX_SYNC, 8'h15, `SFR_RESP_OKAY);
    wt(2);
    chk(d_rst === 7'h01 && f_rst === 1'b1, "sync divider resets");
    wr(`SFR_IDX_SYNC, 8'h11, `SFR_RESP_OKAY);
    chk(n_d0 === 1 && d_rst[6:1] === 6'h00, "soft sync");
    chk(d_app === 7'h01, "delay applied");
    pin <= 1'b1;
    wt(6);
    pin <= 1'b0;
    wt(6);
    chk(n_d0 === 2, "pin sync");
    wr(`SFR_IDX_MODE, 8'h00, `SFR_RESP_OKAY);
    ref0 <= 1'b1;
    wt(6);
    ref0 <= 1'b0;
    wt(6);
    chk(n_d0 === 3, "ref input sync");
    // bursts started by writes, lane 0 selected
    wr(`SFR_IDX_MODE, 8'h02, `SFR_RESP_OKAY);
    wr(`SFR_IDX_SYNCBLK, 8'hff, `SFR_RESP_OKAY);
    wr(`SFR_IDX_POWER, 8'h00, `SFR_RESP_OKAY);
    wr(`SFR_IDX_LANE, 32'h00007e01, `SFR_RESP_OKAY);
    wr(`SFR_IDX_SYNC, 8'hb3, `SFR_RESP_OKAY);
    wt(15);
    wr(`SFR_IDX_SYNC, 8'hb1, `SFR_RESP_OKAY);
    for (c = 0; c < 4; c = c + 1) begin
      base = n_l0;
      wr(`SFR_IDX_PULSE, c, `SFR_RESP_OKAY);
      wt(120);
      chk(n_l0 - base === (1 << c), "burst length");
    end
    chk(n_l1 === 0, "unselected lane");
    wr(`SFR_IDX_SYNC, 8'hb3, `SFR_RESP_OKAY);
    base = n_l0;
    wr(`SFR_IDX_PULSE, 8'h01, `SFR_RESP_OKAY);
    wt(60);
    chk(n_l0 === base && lane === 7'h00, "pulse in clear");
    // bursts on sync edges
    wr(`SFR_IDX_SYNC, 8'ha1, `SFR_RESP_OKAY);
    base = n_l0;
    pin <= 1'b1;
    wt(60);
    pin <= 1'b0;
    wt(60);
    wr(`SFR_IDX_SYNC, 8'ha5, `SFR_RESP_OKAY);
    wt(60);
    chk(n_l0 - base === 4, "edge bursts");
    // request mode
    wr(`SFR_IDX_MODE, 8'h03, `SFR_RESP_OKAY);
    wr(`SFR_IDX_SYNC, 8'h81, `SFR_RESP_OKAY);
    wt(40);
    base = n_l0;
    pin <= 1'b1;
    wt(80);
    pin <= 1'b0;
    wt(40);
    chk(n_l0 - base >= 8 && n_l0 - base <= 11, "request run");
    chk(lane[0] === 1'b0, "request stop");
    // continuous source
    wr(`SFR_IDX_MODE, 8'h02, `SFR_RESP_OKAY);
    wr(`SFR_IDX_POWER, 8'h04, `SFR_RESP_OKAY);
    wr(`SFR_IDX_SYNC, 8'hc1, `SFR_RESP_OKAY);
    base = n_l0;
    wt(80);
    chk(n_l0 - base >= 8 && n_l0 - base <= 11, "continuous");
    // re-clocked sync on divider 0
    wr(`SFR_IDX_SYNC, 8'h51, `SFR_RESP_OKAY);
    wr(`SFR_IDX_SYNCBLK, 8'hfe, `SFR_RESP_OKAY);
    base = n_d0;
    pin <= 1'b1;
    wt(20);
    chk(n_d0 - base === 1 && d_rst === 7'h01, "re-clocked sync");
    pin <= 1'b0;
    wt(20);
    chk(d_rst === 7'h00, "re-clocked release");
    // direct fan-out
    wr(`SFR_IDX_POWER, 8'h07, `SFR_RESP_OKAY);
    wr(`SFR_IDX_MODE, 8'h00, `SFR_RESP_OKAY);
    wr(`SFR_IDX_SYNC, 8'h00, `SFR_RESP_OKAY);
    ext <= 1'b1;
    wt(4);
    chk(lane[1:0] === 2'b01, "direct high");
    ext <= 1'b0;
    wt(4);
    chk(lane[0] === 1'b0, "direct low");
    give_verdict;
  end
endmodule
